//--- design/fsp_defines.svh
// Offsets, field positions, reset values and timing counts for the flash
// self-program controller.
// Assumes a 32-bit APB slave at 250 MHz; included by its bare name.
`ifndef FSP_DEFINES_SVH
`define FSP_DEFINES_SVH

`define FSP_OFF_CONTROL 12'h000
`define FSP_OFF_KEY 12'h004
`define FSP_OFF_DEST_UPPER 12'h008
`define FSP_OFF_DEST_LOWER 12'h00c
`define FSP_OFF_PAGE 12'h010
`define FSP_OFF_TBL_ADDR 12'h014
`define FSP_OFF_TBL_DATA 12'h018
`define FSP_OFF_TBL_CMD 12'h01c

`define FSP_BIT_LAUNCH 15
`define FSP_BIT_PERMIT 14
`define FSP_BIT_FAULT 13
`define FSP_BIT_IDLE_OFF 12

`define FSP_KEY_FIRST 8'h55
`define FSP_KEY_SECOND 8'haa

`define FSP_OP_DWORD 4'h1
`define FSP_OP_ROW 4'h2
`define FSP_OP_BLOCK_ERASE 4'h3
`define FSP_OP_CHIP_ERASE 4'he

`define FSP_ROW_WORDS 128
`define FSP_BLOCK_WORDS 1024
`define FSP_ROW_BYTES 384
`define FSP_BLOCK_BYTES 3072

`define FSP_CONTROL_RESET 16'h0000
`define FSP_LATCH_WORD_NS 8

`endif

//--- design/fsp_pkg.sv
// Types shared by the flash self-program controller files.
// Assumes the defines header is compiled alongside.
package fsp_pkg;

  typedef enum logic [1:0] {
    KEY_NONE,
    KEY_HALF,
    KEY_ARMED
  } fsp_key_type;

  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_LOAD,
    SEQ_RUN,
    SEQ_DONE
  } fsp_seq_type;

endpackage

//--- design/fsp_latch_bank.sv
// Row-wide holding latches: 128 words of 24 bits with byte write enables.
// Assumes one write and one read per cycle; contents are unknown after reset.
`timescale 1ns/10ps
module fsp_latch_bank (
  input wire logic clk,
  input wire logic wr_en,
  input wire logic [6:0] wr_index,
  input wire logic [2:0] wr_bytes,
  input wire logic [23:0] wr_data,
  input wire logic [6:0] rd_index,
  output logic [23:0] rd_data
);

  logic [23:0] mem [0:127];
  logic [23:0] rd_q;

  // Last write to a slot wins; any order is legal.
  always_ff @(posedge clk) begin
    for (int b = 0; b < 3; b++) begin
      if (wr_en && wr_bytes[b]) begin
        mem[wr_index][b*8 +: 8] <= wr_data[b*8 +: 8]; // RQ10
      end
    end
    rd_q <= mem[rd_index];
  end

  assign rd_data = rd_q;

endmodule

//--- design/fsp_op_timer.sv
// Self-timed operation counter: counts down a length and reports done.
// Assumes start is a one-cycle pulse while idle.
`timescale 1ns/10ps
module fsp_op_timer (
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input wire logic [19:0] length,
  output logic busy,
  output logic done
);

  typedef struct packed {
    logic [19:0] count;
    logic busy;
    logic done;
  } fsp_timer_state_type;

  fsp_timer_state_type s_q;
  fsp_timer_state_type s_d;

  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    if (start && !s_q.busy) begin
      s_d.busy = 1'b1;
      s_d.count = length;
    end else if (s_q.busy) begin
      if (s_q.count <= 20'h00001) begin
        s_d.busy = 1'b0;
        s_d.done = 1'b1;
        s_d.count = 20'h00000;
      end else begin
        s_d.count = s_q.count - 20'h00001;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign busy = s_q.busy;
  assign done = s_q.done;

endmodule

//--- design/fsp_ctrl.sv
// Flash self-program controller: APB registers, table access, unlock key,
// holding latch load and the self-timed program/erase sequencer.
// Assumes a flash array port that takes one 24-bit word per cycle while
// ARR_WE is high and acknowledges erase via the sequencer's own timer.
//
// Function
// [RQ1] Target address is page select byte joined to the 16-bit offset.
// [RQ2] Low table accesses reach bits 15..0, word or byte wide.
// [RQ3] High table accesses reach bits 23..16, word or byte wide.
// [RQ4] A row holds 128 instruction words, 384 bytes.
// [RQ5] Erase works on 1024-word blocks; program on a row or two words.
// [RQ6] Erase and row blocks align on 3072- and 384-byte boundaries.
// [RQ7] Table writes go to holding latches, never straight to the array.
// [RQ8] Any number of loaded latch words programs; 128 fill a row.
// [RQ9] Software fills unused latches with all ones; latches reset unknown.
// [RQ10] Latches load in any order; the last write to a slot wins.
// [RQ11] Table write is one latch word in two cycles; each row commits alone.
// [RQ12] Key register is write-only; 55h then AAh arms a launch.
// [RQ13] Destination holds upper byte and lower word; chip erase ignores it.
// [RQ14] The core is stalled while an operation runs.
// [RQ15] Control bit 15 launches; hardware clears it at completion.
// [RQ16] Control bit 14 permits operations; when clear all are inhibited.
// [RQ17] Control bit 13 flags faulty sequences; clear after normal completion.
// [RQ18] Row program needs code 0010, permit, key, then launch.
// [RQ19] Block erase needs its code and permit before address and key.
// [RQ20] Launch only right after the full key; otherwise flag a fault.
`timescale 1ns/10ps
`include "fsp_defines.svh"
module fsp_ctrl #(
  parameter logic [19:0] ERASE_CYCLES = 20'd5000,
  parameter logic [19:0] CHIP_ERASE_CYCLES = 20'd20000
) (
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic CORE_IDLE,
  output logic CORE_STALL,
  output logic ARR_POWER_OFF,
  output logic ARR_WE,
  output logic ARR_ERASE,
  output logic [3:0] ARR_OP,
  output logic [23:0] ARR_ADDR,
  output logic [23:0] ARR_WDATA,
  input wire logic [23:0] ARR_RDATA
);

  // ****************************************************************
  // Register state
  // ****************************************************************
  typedef struct packed {
    logic launch;
    logic permit;
    logic fault;
    logic idle_off;
    logic [3:0] op_code;
    logic [7:0] dest_upper;
    logic [15:0] dest_lower;
    logic [7:0] page;
    logic [15:0] tbl_offset;
    logic [23:0] tbl_data;
    fsp_pkg::fsp_key_type key;
    fsp_pkg::fsp_seq_type seq;
    logic [6:0] load_idx;
    logic [6:0] load_last;
    logic [23:0] base;
    logic wait_rd;
    logic [31:0] prdata;
    logic we;
    logic erase;
    logic [23:0] addr;
    logic [23:0] wdata;
  } fsp_ctrl_state_type;

  fsp_ctrl_state_type s_q;
  fsp_ctrl_state_type s_d;

  logic [23:0] latch_rd;
  logic latch_we;
  logic [2:0] latch_bytes;
  logic [23:0] latch_wdata;
  logic timer_start;
  logic [19:0] timer_len;
  logic timer_busy;
  logic timer_done;
  logic access;
  logic wr_acc;
  logic rd_acc;
  logic [23:0] tgt;
  logic hit;
  logic [6:0] latch_rd_idx;

  // Full program-memory address from page byte and offset.
  function automatic logic [23:0] prog_addr(input logic [7:0] pg,
                                            input logic [15:0] off);
    prog_addr = {pg, off}; // RQ1
  endfunction

  // Align a destination down to the start of its row, word pair or erase block.
  function automatic logic [23:0] align_base(input logic [3:0] op,
                                             input logic [23:0] a);
    unique case (op)
      `FSP_OP_BLOCK_ERASE: align_base = {a[23:11], 11'h000}; // RQ6
      `FSP_OP_ROW: align_base = {a[23:8], 8'h00}; // RQ6
      `FSP_OP_DWORD: align_base = {a[23:2], 2'b00};
      default: align_base = 24'h000000; // RQ13
    endcase
  endfunction

  function automatic logic op_legal(input logic [3:0] op);
    op_legal = (op == `FSP_OP_DWORD) || (op == `FSP_OP_ROW) ||
               (op == `FSP_OP_BLOCK_ERASE) || (op == `FSP_OP_CHIP_ERASE);
  endfunction

  assign access = PSEL && PENABLE;
  assign wr_acc = access && PWRITE && PREADY;
  assign rd_acc = access && !PWRITE && PREADY;
  assign tgt = prog_addr(s_q.page, s_q.tbl_offset);
  assign hit = (PADDR[11:5] == 7'h00) && (PADDR[1:0] == 2'b00);

  // A table read takes one extra cycle for the latch or array answer.
  assign PREADY = !(access && !PWRITE && PADDR == `FSP_OFF_TBL_DATA &&
                    !s_q.wait_rd);
  assign PSLVERR = access && !hit;

  // ****************************************************************
  // Table command: bit 0 high selects high byte, bits 2..1 byte lanes
  // ****************************************************************
  always_comb begin
    latch_we = 1'b0;
    latch_bytes = 3'b000;
    latch_wdata = 24'h000000;
    if (wr_acc && PADDR == `FSP_OFF_TBL_CMD && s_q.seq == fsp_pkg::SEQ_IDLE)
    begin
      latch_we = 1'b1; // RQ7
      latch_wdata = {PWDATA[23:16], s_q.tbl_data[15:0]};
      if (PWDATA[0]) begin
        latch_bytes = 3'b100; // RQ3
        latch_wdata = {s_q.tbl_data[7:0], s_q.tbl_data[15:0]};
      end else begin
        latch_bytes = {1'b0, PWDATA[2:1]}; // RQ2
      end
    end
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    s_d = s_q;
    s_d.we = 1'b0;
    s_d.erase = 1'b0;
    timer_start = 1'b0;
    timer_len = ERASE_CYCLES;
    if (rd_acc) begin
      s_d.wait_rd = 1'b0;
    end else if (access && !PWRITE && PADDR == `FSP_OFF_TBL_DATA) begin
      s_d.wait_rd = 1'b1;
    end
    if (wr_acc) begin
      unique case (PADDR)
        `FSP_OFF_CONTROL: begin
          s_d.permit = PWDATA[`FSP_BIT_PERMIT];
          s_d.idle_off = PWDATA[`FSP_BIT_IDLE_OFF];
          s_d.op_code = PWDATA[3:0];
          s_d.key = fsp_pkg::KEY_NONE;
          if (PWDATA[`FSP_BIT_LAUNCH] && !s_q.launch) begin
            if (s_q.key == fsp_pkg::KEY_ARMED &&
                PWDATA[`FSP_BIT_PERMIT] && op_legal(PWDATA[3:0])) begin
              s_d.launch = 1'b1; // RQ20
              s_d.fault = 1'b0; // RQ17
              s_d.base = align_base(PWDATA[3:0],
                                    {s_q.dest_upper, s_q.dest_lower});
              s_d.load_idx = 7'h00;
              s_d.seq = fsp_pkg::SEQ_LOAD;
              if (PWDATA[3:0] == `FSP_OP_ROW) begin
                s_d.load_last = 7'h7f; // RQ4
              end else if (PWDATA[3:0] == `FSP_OP_DWORD) begin
                s_d.load_last = 7'h01; // RQ5
              end else begin
                s_d.seq = fsp_pkg::SEQ_RUN; // RQ5
                timer_start = 1'b1;
                s_d.erase = 1'b1;
                if (PWDATA[3:0] == `FSP_OP_CHIP_ERASE) begin
                  timer_len = CHIP_ERASE_CYCLES;
                end
              end
            end else begin
              s_d.fault = 1'b1; // RQ16
            end
          end
        end
        `FSP_OFF_KEY: begin
          if (PWDATA[7:0] == `FSP_KEY_FIRST) begin
            s_d.key = fsp_pkg::KEY_HALF; // RQ12
          end else if (PWDATA[7:0] == `FSP_KEY_SECOND &&
                       s_q.key == fsp_pkg::KEY_HALF) begin
            s_d.key = fsp_pkg::KEY_ARMED;
          end else begin
            s_d.key = fsp_pkg::KEY_NONE;
          end
        end
        `FSP_OFF_DEST_UPPER: s_d.dest_upper = PWDATA[7:0];
        `FSP_OFF_DEST_LOWER: s_d.dest_lower = PWDATA[15:0];
        `FSP_OFF_PAGE: s_d.page = PWDATA[7:0];
        `FSP_OFF_TBL_ADDR: s_d.tbl_offset = PWDATA[15:0];
        `FSP_OFF_TBL_DATA: s_d.tbl_data = PWDATA[23:0];
        default: ;
      endcase
      if (PADDR != `FSP_OFF_KEY && PADDR != `FSP_OFF_CONTROL) begin
        s_d.key = fsp_pkg::KEY_NONE;
      end
    end
    if (s_q.seq == fsp_pkg::SEQ_LOAD) begin
      // Each latch word goes to the array in its own cycle.
      s_d.we = 1'b1; // RQ8
      s_d.addr = s_q.base + {16'h0000, s_q.load_idx, 1'b0}; // RQ4
      s_d.wdata = latch_rd;
      if (s_q.load_idx == s_q.load_last) begin
        s_d.seq = fsp_pkg::SEQ_RUN; // RQ11
        timer_start = 1'b1;
      end else begin
        s_d.load_idx = s_q.load_idx + 7'h01;
      end
    end
    if (s_q.seq == fsp_pkg::SEQ_RUN && timer_done) begin
      s_d.seq = fsp_pkg::SEQ_IDLE;
      s_d.launch = 1'b0; // RQ15
    end
    // Read data is registered in the setup cycle and in any wait state, so
    // it already stands on PRDATA at the edge that completes the transfer.
    if (PSEL && !PWRITE && !rd_acc) begin
      unique case (PADDR)
        `FSP_OFF_CONTROL: s_d.prdata = {16'h0000, s_q.launch, s_q.permit,
                                        s_q.fault, s_q.idle_off, 8'h00,
                                        s_q.op_code};
        `FSP_OFF_DEST_UPPER: s_d.prdata = {24'h000000, s_q.dest_upper};
        `FSP_OFF_DEST_LOWER: s_d.prdata = {16'h0000, s_q.dest_lower};
        `FSP_OFF_PAGE: s_d.prdata = {24'h000000, s_q.page};
        `FSP_OFF_TBL_ADDR: s_d.prdata = {16'h0000, s_q.tbl_offset};
        `FSP_OFF_TBL_DATA: begin
          if (s_q.page[7]) begin
            s_d.prdata = {8'h00, latch_rd};
          end else begin
            s_d.prdata = {8'h00, ARR_RDATA};
          end
        end
        default: s_d.prdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************************************
  // Sub-blocks and outputs
  // ****************************************************************
  // The latch read is registered, so the sequencer asks one word ahead and
  // fetches word 0 in the launch cycle itself.
  assign latch_rd_idx = (s_q.seq == fsp_pkg::SEQ_LOAD) ?
                        (s_q.load_idx + 7'h01) :
                        ((s_d.seq == fsp_pkg::SEQ_LOAD) ? 7'h00 : tgt[7:1]);

  fsp_latch_bank u_latch (
    .clk(SYS_CLK),
    .wr_en(latch_we),
    .wr_index(tgt[7:1]),
    .wr_bytes(latch_bytes),
    .wr_data(latch_wdata),
    .rd_index(latch_rd_idx),
    .rd_data(latch_rd)
  );

  fsp_op_timer u_timer (
    .clk(SYS_CLK),
    .rst(RST),
    .start(timer_start),
    .length(timer_len),
    .busy(timer_busy),
    .done(timer_done)
  );

  assign PRDATA = s_q.prdata;
  assign CORE_STALL = s_q.launch; // RQ14
  assign ARR_POWER_OFF = s_q.idle_off && CORE_IDLE && !timer_busy;
  assign ARR_WE = s_q.we;
  assign ARR_ERASE = s_q.erase;
  assign ARR_OP = s_q.op_code;
  assign ARR_ADDR = s_q.we ? s_q.addr : (s_q.erase ? s_q.base : tgt);
  assign ARR_WDATA = s_q.wdata;

endmodule

//--- verif/fsp_ctrl_monitor.sv
// Port checker for the flash self-program controller.
// Assumes binding to fsp_ctrl: one clock, synchronous active-high reset.
`timescale 1ns/10ps
module fsp_ctrl_monitor (
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PSLVERR,
  input wire logic CORE_IDLE,
  input wire logic CORE_STALL,
  input wire logic ARR_POWER_OFF,
  input wire logic ARR_WE,
  input wire logic ARR_ERASE
);
  // ****
  // Properties
  // ****
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  logic wr_ctl;
  assign wr_ctl = PSEL && PENABLE && PWRITE && PADDR == 12'h000;
  a_stall_cause: assert property ($rose(CORE_STALL) |->
    $past(wr_ctl && PWDATA[15])) else $error("stall without launch");
  a_stall_bound: assert property ($rose(CORE_STALL) |->
    ##[1:400] !CORE_STALL) else $error("stall never ends");
  a_stall_hold: assert property ($rose(CORE_STALL) |->
    CORE_STALL [*8]) else $error("operation ended too soon");
  a_we_stalled: assert property (ARR_WE |-> CORE_STALL)
    else $error("array write outside an operation");
  a_erase_once: assert property (ARR_ERASE |->
    CORE_STALL ##1 !ARR_ERASE) else $error("erase pulse wrong");
  a_key_hidden: assert property (PSEL && PENABLE && !PWRITE &&
    PADDR == 12'h004 |-> PRDATA == 32'h0) else $error("key readable");
  a_unmapped_err: assert property (PSEL && PENABLE &&
    PADDR >= 12'h020 |-> PSLVERR) else $error("no error on hole");
  a_power_idle: assert property (ARR_POWER_OFF |-> CORE_IDLE)
    else $error("array off while core runs");
  cover property ($rose(CORE_STALL));
  cover property (ARR_ERASE);
  cover property (PSLVERR);
  cover property (ARR_POWER_OFF);
endmodule
bind fsp_ctrl fsp_ctrl_monitor fsp_ctrl_monitor_i (.SYS_CLK(SYS_CLK),
  .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
  .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PSLVERR(PSLVERR),
  .CORE_IDLE(CORE_IDLE), .CORE_STALL(CORE_STALL),
  .ARR_POWER_OFF(ARR_POWER_OFF), .ARR_WE(ARR_WE), .ARR_ERASE(ARR_ERASE));

//--- verif/fsp_array_model.sv
// Behavioural flash array on the far side of the controller.
// Assumes a small address space: only the low 12 address bits are kept.
`timescale 1ns/10ps
module fsp_array_model (
  input wire logic clk,
  input wire logic we,
  input wire logic erase,
  input wire logic [23:0] addr,
  input wire logic [23:0] wdata,
  output logic [23:0] rdata
);
  // ****
  // Storage
  // ****
  logic [23:0] mem [0:4095];
  initial begin
    for (int i = 0; i < 4096; i++) mem[i] = 24'hffffff;
  end
  // Any erase wipes the whole model, which is cruder than a block erase.
  always @(posedge clk) begin
    if (erase === 1'b1) begin
      for (int i = 0; i < 4096; i++) mem[i] <= 24'hffffff;
    end
    if (we === 1'b1) mem[addr[11:0]] <= wdata;
  end
  assign rdata = mem[addr[11:0]];
endmodule

//--- verif/testbench.sv
// Self-checking bench: APB master, flash array model, row and erase runs.
// Assumes the design header and package are compiled first.
`timescale 1ns/10ps
`include "fsp_defines.svh"
module testbench;
  logic clk, rst, psel, penable, pwrite, core_idle, pready, err;
  logic pslverr, core_stall, pwr_off, arr_we, arr_erase;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [3:0] arr_op;
  logic [23:0] arr_addr, arr_wdata, arr_rdata;
  int num_errors, n_tests, n_we, n_er, n_st, k, w0, e0, s0;
  fsp_ctrl #(.ERASE_CYCLES(20'd20), .CHIP_ERASE_CYCLES(20'd40)) fsp_ctrl_i (
    .SYS_CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .CORE_IDLE(core_idle),
    .CORE_STALL(core_stall), .ARR_POWER_OFF(pwr_off), .ARR_WE(arr_we),
    .ARR_ERASE(arr_erase), .ARR_OP(arr_op), .ARR_ADDR(arr_addr),
    .ARR_WDATA(arr_wdata), .ARR_RDATA(arr_rdata));
  fsp_array_model fsp_array_model_i (.clk(clk), .we(arr_we),
    .erase(arr_erase), .addr(arr_addr), .wdata(arr_wdata),
    .rdata(arr_rdata));
  initial begin
    clk = 0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    n_we <= n_we + (arr_we === 1'b1);
    n_er <= n_er + (arr_erase === 1'b1);
    n_st <= n_st + (core_stall === 1'b1);
  end
  // ****
  // Tasks
  // ****
  task automatic conclude;
    $display("counts: %0d compares, %0d mismatches", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, exp, input string m);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t %s: got %h want %h", $time, m, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    rdat = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    if (pready !== 1'b1) begin
      num_errors++;
      conclude();
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic load(input logic [15:0] off, input logic [23:0] v,
      input logic [2:0] cmd);
    wr(`FSP_OFF_TBL_ADDR, {16'h0, off});
    wr(`FSP_OFF_TBL_DATA, {8'h0, v});
    wr(`FSP_OFF_TBL_CMD, {29'h0, cmd});
  endtask
  // A stuck stall would hang the core, so the wait is bounded.
  task automatic attempt(input logic [15:0] ctl, input bit brk);
    w0 = n_we;
    e0 = n_er;
    s0 = n_st;
    wr(`FSP_OFF_CONTROL, {16'h0, ctl & 16'h7fff});
    wr(`FSP_OFF_KEY, 32'h55);
    if (brk) wr(`FSP_OFF_PAGE, 32'h0);
    wr(`FSP_OFF_KEY, 32'haa);
    wr(`FSP_OFF_CONTROL, {16'h0, ctl});
    repeat (2) @(posedge clk);
    for (k = 0; k < 500 && core_stall !== 1'b0; k++) @(posedge clk);
    if (core_stall !== 1'b0) begin
      num_errors++;
      conclude();
    end
    rd(`FSP_OFF_CONTROL);
  endtask
  // ****
  // Sequence
  // ****
  logic [15:0] bad [3] = '{16'hc002, 16'h8002, 16'hc005};
  logic [3:0] ops [3] = '{4'h1, 4'h3, 4'he};
  initial begin
    {rst, psel, penable, pwrite, paddr, pwdata, core_idle} = '1;
    {psel, penable, pwrite, paddr, pwdata, core_idle} = '0;
    {num_errors, n_tests} = '0;
    repeat (5) @(posedge clk);
    rst <= 0;
    rd(`FSP_OFF_CONTROL);
    check(rdat, 32'h0, "control reset");
    wr(`FSP_OFF_KEY, 32'h55);
    rd(`FSP_OFF_KEY);
    check(rdat, 32'h0, "key readback");
    rd(12'h020);
    check({31'h0, err}, 32'h1, "hole error");
    $display("test registers done");
    for (int i = 0; i < 3; i++) begin
      attempt(bad[i], i == 0);
      check({rdat[15], rdat[13]}, 32'h1, "fault flag");
      check(n_st - s0, 0, "refused launch ran");
    end
    wr(`FSP_OFF_CONTROL, 32'h4002);
    wr(`FSP_OFF_CONTROL, 32'hc002);
    repeat (3) @(posedge clk);
    check(n_st, 0, "launch without key ran");
    $display("test refusals done");
    wr(`FSP_OFF_PAGE, 32'h80);
    load(16'h0004, 24'h654321, 3'b110);
    load(16'h0002, 24'h123456, 3'b110);
    load(16'h0002, 24'h0000ab, 3'b001);
    load(16'h0002, 24'h000077, 3'b010);
    rd(`FSP_OFF_TBL_DATA);
    check(rdat, 32'h00ab3477, "latch merge");
    check(n_we, 0, "table write reached array");
    $display("test latches done");
    for (int i = 0; i < 128; i++) begin
      load({8'h0, i[6:0], 1'b0}, {8'h3c, i[7:0], 8'h3c}, 3'b110);
      wr(`FSP_OFF_TBL_CMD, 32'h1);
    end
    wr(`FSP_OFF_DEST_UPPER, 32'h0);
    wr(`FSP_OFF_DEST_LOWER, 32'h0100);
    attempt(16'hc002, 0);
    check(n_we - w0, 128, "row words");
    check(rdat, 32'h4002, "row done");
    wr(`FSP_OFF_PAGE, 32'h0);
    wr(`FSP_OFF_TBL_ADDR, 32'h010a);
    rd(`FSP_OFF_TBL_DATA);
    check(rdat, 32'h003c053c, "array word");
    $display("test row done");
    for (int i = 0; i < 3; i++) begin
      attempt({12'hc00, ops[i]}, 0);
      check(n_we - w0, ops[i] == 4'h1 ? 2 : 0, "dword words");
      check(n_er - e0, ops[i] != 4'h1, "erase pulses");
      check(rdat, {20'h00004, 8'h00, ops[i]}, "op done");
      check({28'h0, arr_op}, {28'h0, ops[i]}, "op code out");
    end
    $display("test ops done");
    wr(`FSP_OFF_CONTROL, 32'h1000);
    core_idle <= 1;
    repeat (2) @(posedge clk);
    check({31'h0, pwr_off}, 32'h1, "idle power off");
    core_idle <= 0;
    repeat (2) @(posedge clk);
    check({31'h0, pwr_off}, 32'h0, "power back on");
    $display("test idle done");
    conclude();
  end
endmodule
